// File: lpfw_pkg.sv
/*
 * package for the low-power freeze and wake controller: command codes,
 * pin wake roles, sequencer states, timing constants.
 * assumes a single 25 MHz system clock.
 */
package lpfw_pkg;
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned RTC_HZ        = 1_000_000;
    // rtc tick divider, rounded down so the tick never runs slow
    localparam int unsigned RTC_DIV       = (CLK_HZ / RTC_HZ < 1) ? 1 : CLK_HZ / RTC_HZ;
    localparam int unsigned RTC_W         = 32;
    localparam logic [7:0]  CMD_FREEZE    = 8'h4e;
    localparam logic [7:0]  CMD_NOTICE    = 8'he0;
    localparam logic [7:0]  CMD_ABORT     = 8'hfa;
    localparam logic [7:0]  CMD_OK        = 8'h00;
    // freeze option bit positions in the first sub-command byte
    localparam int unsigned OPT_FABRIC    = 0;
    localparam int unsigned OPT_NVM       = 1;
    localparam int unsigned OPT_PLL       = 2;
    localparam int unsigned OPT_RETAIN    = 3;
    localparam int unsigned OPT_RTC       = 4;
    // per-pin wake role
    typedef enum logic [1:0] {
        ROLE_OFF    = 2'h0,
        ROLE_ON_0   = 2'h1,
        ROLE_ON_1   = 2'h2,
        ROLE_CHANGE = 2'h3
    } lpfw_role_e;
    typedef enum {
        ST_IDLE,
        ST_OPTS,
        ST_NOTICE,
        ST_DOWN,
        ST_FROZEN,
        ST_EXIT
    } lpfw_state_e;
endpackage

// File: lpfw_wake_eval.sv
/*
 * wake evaluator: synchronises wake pins, latches activity references at
 * entry, and forms the combined pin wake decision.
 * assumes i_mclk is the low-power oscillator used during freeze.
 */
`timescale 1ns/10ps
`default_nettype none
module lpfw_wake_eval
    import lpfw_pkg::*;
#(
    parameter int unsigned N_PINS = 8
) (
    input  wire logic              i_mclk,
    input  wire logic              i_resetn,
    input  wire logic [N_PINS-1:0] i_pins,
    input  wire logic [N_PINS-1:0] i_single_ended,
    input  wire logic [2*N_PINS-1:0] i_roles,
    input  wire logic              i_capture,
    input  wire logic              i_armed,
    output logic                   o_wake
);
    // elaboration check: the pin vectors need at least one bit
    if (N_PINS < 1) begin : g_chk_pins
        $error("N_PINS must be at least 1");
    end

    logic [N_PINS-1:0] meta_q, meta_d;
    logic [N_PINS-1:0] sync_q, sync_d;
    logic [N_PINS-1:0] ref_q, ref_d;
    logic [N_PINS-1:0] sig_ok;
    logic [N_PINS-1:0] act_hit;
    logic              wake_q, wake_d;

    ////////////////////////////////////////////////////////////////////////
    // per-pin conditions; off or differential pins drop out
    genvar g;
    generate
        for (g = 0; g < N_PINS; g++) begin : g_pin
            lpfw_role_e role;
            assign role = lpfw_role_e'(i_roles[2*g +: 2]);
            // pins with no role count as matched, so they never block the and
            assign sig_ok[g] = !i_single_ended[g] ? 1'b1 :
                               (role == ROLE_ON_1) ? sync_q[g] :
                               (role == ROLE_ON_0) ? !sync_q[g] : 1'b1;
            assign act_hit[g] = i_single_ended[g] && role == ROLE_CHANGE
                                && (sync_q[g] != ref_q[g]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // signature needs at least one signature pin, else and of none is true
    function automatic logic any_sig(input logic [2*N_PINS-1:0] r,
                                     input logic [N_PINS-1:0] se);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < N_PINS; i++) begin
            if (se[i] && (r[2*i +: 2] == ROLE_ON_0 || r[2*i +: 2] == ROLE_ON_1)) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // two-flop sync, reference latch and the combined decision
    always_comb begin
        meta_d = i_pins;
        sync_d = meta_q;
        ref_d  = i_capture ? sync_q : ref_q;
        wake_d = i_armed && ((any_sig(i_roles, i_single_ended) && &sig_ok)
                             || |act_hit);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            meta_q <= '0;
            sync_q <= '0;
            ref_q  <= '0;
            wake_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            ref_q  <= ref_d;
            wake_q <= wake_d;
        end
    end

    assign o_wake = wake_q;
endmodule
`default_nettype wire

// File: lpfw_rtc.sv
/*
 * binary wake counter: 1 MHz tick enable derived from the system clock,
 * counts up in binary and flags a match or a software force.
 * assumes the system clock stands in for the low-frequency oscillator.
 */
`timescale 1ns/10ps
`default_nettype none
module lpfw_rtc
    import lpfw_pkg::*;
#(
    parameter int unsigned DIV = RTC_DIV
) (
    input  wire logic             i_mclk,
    input  wire logic             i_resetn,
    input  wire logic             i_run,
    input  wire logic [RTC_W-1:0] i_match,
    input  wire logic             i_force,
    output logic                  o_wake
);
    // elaboration check: a zero divider would never tick
    if (DIV < 1) begin : g_chk_div
        $error("DIV must be at least 1");
    end

    localparam int unsigned DW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

    logic [DW-1:0]    div_q, div_d;
    logic [RTC_W-1:0] cnt_q, cnt_d;
    logic             wake_q, wake_d;
    logic             tick;

    ////////////////////////////////////////////////////////////////////////
    // divider tick and binary count; cleared while not running
    assign tick = (div_q == DIV_LAST);
    always_comb begin
        div_d  = (!i_run || tick) ? '0 : div_q + DW'(1);
        cnt_d  = !i_run ? '0 : (tick ? cnt_q + RTC_W'(1) : cnt_q);
        // force sets the interrupt whether or not the counter runs
        wake_d = i_force || (i_run && tick && (cnt_q + RTC_W'(1) == i_match))
                 || (wake_q && i_run);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            div_q  <= '0;
            cnt_q  <= '0;
            wake_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            cnt_q  <= cnt_d;
            wake_q <= wake_d;
        end
    end

    assign o_wake = wake_q;
endmodule
`default_nettype wire

// File: lpfw_ctrl.sv
/*
 * low-power freeze and wake controller top: takes service commands over
 * the service command channel, notifies the processor, shuts blocks down,
 * holds pins, and leaves freeze on pin or counter wake.
 * assumes command bytes and channel ready are synchronous to i_mclk.
 */
`timescale 1ns/10ps
`default_nettype none

module lpfw_ctrl
    import lpfw_pkg::*;
#(
    parameter int unsigned N_PINS = 8
) (
    input  wire logic                i_mclk,
    input  wire logic                i_resetn,
    // service command channel, request side
    input  wire logic                i_cmd_valid,
    input  wire logic [7:0]          i_cmd_data,
    output logic                     o_cmd_ready,
    output logic                     o_rsp_valid,
    output logic [7:0]               o_rsp_data,
    // notice byte into the processor-side receive fifo
    output logic                     o_notice_valid,
    output logic [7:0]               o_notice_data,
    input  wire logic                i_notice_ready,
    // rtc setup and processor force
    input  wire logic [RTC_W-1:0]    i_rtc_match,
    input  wire logic                i_rtc_wake_force,
    // pins
    input  wire logic [N_PINS-1:0]   i_pin_in,
    input  wire logic [N_PINS-1:0]   i_pin_out,
    input  wire logic [N_PINS-1:0]   i_pin_oe,
    input  wire logic [N_PINS-1:0]   i_pin_single_ended,
    input  wire logic [2*N_PINS-1:0] i_pin_role,
    input  wire logic [N_PINS-1:0]   i_pin_hold,
    output logic [N_PINS-1:0]        o_pin_out,
    output logic [N_PINS-1:0]        o_pin_oe,
    // block shutdown controls
    output logic                     o_fabric_en,
    output logic                     o_nvm_en,
    output logic                     o_pll_en,
    output logic                     o_sram_retain,
    output logic                     o_sram_power,
    // wake interrupt copies and fabric indications
    output logic                     o_rtc_wake_sysctl,
    output logic                     o_rtc_wake_fabric,
    output logic                     o_rtc_wake_nvic,
    output logic                     o_freeze_entry_notice,
    output logic                     o_freeze_exit_done,
    output logic                     o_frozen
);
    // elaboration check: the pin vectors need at least one bit
    if (N_PINS < 1) begin : g_chk_pins
        $error("N_PINS must be at least 1");
    end

    lpfw_state_e        st_q, st_d;
    logic [7:0]         opts_q, opts_d;
    logic [N_PINS-1:0]  hold_out_q, hold_out_d;
    logic [N_PINS-1:0]  hold_oe_q, hold_oe_d;
    logic               rsp_v_q, rsp_v_d;
    logic [7:0]         rsp_q, rsp_d;
    logic               entry_q, entry_d;
    logic               done_q, done_d;
    logic               pin_wake;
    logic               rtc_wake;
    logic               capture;
    logic               armed;

    ////////////////////////////////////////////////////////////////////////
    // wake sources
    assign capture = (st_q == ST_DOWN);
    assign armed   = (st_q == ST_FROZEN);

    lpfw_wake_eval #(
        .N_PINS (N_PINS)
    ) u_wake (
        .i_mclk         (i_mclk),
        .i_resetn       (i_resetn),
        .i_pins         (i_pin_in),
        .i_single_ended (i_pin_single_ended),
        .i_roles        (i_pin_role),
        .i_capture      (capture),
        .i_armed        (armed),
        .o_wake         (pin_wake)
    );

    // counter runs only in freeze when the rtc option was given
    lpfw_rtc #(
        .DIV (RTC_DIV)
    ) u_rtc (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_run    (armed && opts_q[OPT_RTC]),
        .i_match  (i_rtc_match),
        .i_force  (i_rtc_wake_force),
        .o_wake   (rtc_wake)
    );

    // one interrupt, three destinations
    assign o_rtc_wake_sysctl = rtc_wake;
    assign o_rtc_wake_fabric = rtc_wake;
    assign o_rtc_wake_nvic   = rtc_wake;

    ////////////////////////////////////////////////////////////////////////
    // command channel is always ready so busy requests can be aborted
    assign o_cmd_ready    = 1'b1;
    assign o_notice_valid = (st_q == ST_NOTICE);
    assign o_notice_data  = CMD_NOTICE;

    // sequencer next state
    always_comb begin
        st_d       = st_q;
        opts_d     = opts_q;
        hold_out_d = hold_out_q;
        hold_oe_d  = hold_oe_q;
        rsp_v_d    = 1'b0;
        rsp_d      = rsp_q;
        entry_d    = entry_q;
        done_d     = done_q;
        unique case (st_q)
            ST_IDLE: begin
                // freeze command byte, options follow as next byte
                if (i_cmd_valid && i_cmd_data == CMD_FREEZE) begin
                    st_d = ST_OPTS;
                end
            end
            ST_OPTS: begin
                if (i_cmd_valid) begin
                    opts_d  = i_cmd_data;
                    st_d    = ST_NOTICE;
                    entry_d = 1'b1;
                    done_d  = 1'b0;
                end
            end
            ST_NOTICE: begin
                // stall until the receive fifo takes the notice
                if (i_notice_ready) begin
                    st_d = ST_DOWN;
                end
            end
            ST_DOWN: begin
                // freeze pin states for the hold option
                hold_out_d = i_pin_out;
                hold_oe_d  = i_pin_oe;
                st_d       = ST_FROZEN;
                rsp_v_d    = 1'b1;
                rsp_d      = CMD_OK;
            end
            ST_FROZEN: begin
                if (pin_wake || rtc_wake) begin
                    st_d = ST_EXIT;
                end
            end
            ST_EXIT: begin
                entry_d = 1'b0;
                done_d  = 1'b1;
                st_d    = ST_IDLE;
            end
        endcase
        // a new request while busy gets an abort answer, state untouched
        if (st_q != ST_IDLE && st_q != ST_OPTS && i_cmd_valid) begin
            rsp_v_d = 1'b1;
            rsp_d   = CMD_ABORT;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            st_q       <= ST_IDLE;
            opts_q     <= '0;
            hold_out_q <= '0;
            hold_oe_q  <= '0;
            rsp_v_q    <= 1'b0;
            rsp_q      <= '0;
            entry_q    <= 1'b0;
            done_q     <= 1'b1;
        end else begin
            st_q       <= st_d;
            opts_q     <= opts_d;
            hold_out_q <= hold_out_d;
            hold_oe_q  <= hold_oe_d;
            rsp_v_q    <= rsp_v_d;
            rsp_q      <= rsp_d;
            entry_q    <= entry_d;
            done_q     <= done_d;
        end
    end

    assign o_rsp_valid           = rsp_v_q;
    assign o_rsp_data            = rsp_q;
    assign o_freeze_entry_notice = entry_q;
    // fabric uses this to gate resets and reset its plls on exit
    assign o_freeze_exit_done    = done_q;
    assign o_frozen              = armed;

    ////////////////////////////////////////////////////////////////////////
    // block shutdown while frozen, per option bit
    assign o_fabric_en   = !(armed && opts_q[OPT_FABRIC]);
    assign o_nvm_en      = !(armed && opts_q[OPT_NVM]);
    assign o_pll_en      = !(armed && opts_q[OPT_PLL]);
    // sram keeps power when retaining; otherwise it is dropped and lost
    assign o_sram_retain = opts_q[OPT_RETAIN];
    assign o_sram_power  = !armed || opts_q[OPT_RETAIN];

    // pin drivers: wake inputs pass, others tristate or hold
    genvar p;
    generate
        for (p = 0; p < N_PINS; p++) begin : g_io
            logic waker;
            assign waker = i_pin_single_ended[p] && i_pin_role[2*p +: 2] != ROLE_OFF;
            assign o_pin_out[p] = (armed && !waker) ? hold_out_q[p] : i_pin_out[p];
            assign o_pin_oe[p]  = (armed && !waker) ? (i_pin_hold[p] && hold_oe_q[p])
                                                    : i_pin_oe[p];
        end
    endgenerate
endmodule
`default_nettype wire

// File: lpfw_ctrl_properties.sv
/* port checker for the freeze and wake controller.
   assumes one clock, sync active-low reset, bound onto lpfw_ctrl. */
`timescale 1ns/10ps
`default_nettype none
module lpfw_ctrl_chk
    import lpfw_pkg::*;
#(
    parameter int unsigned N_PINS = 8
) (
    input wire logic                i_mclk,
    input wire logic                i_resetn,
    input wire logic                i_cmd_valid,
    input wire logic                i_notice_ready,
    input wire logic                i_rtc_wake_force,
    input wire logic [N_PINS-1:0]   i_pin_out,
    input wire logic [N_PINS-1:0]   i_pin_oe,
    input wire logic [N_PINS-1:0]   i_pin_single_ended,
    input wire logic [2*N_PINS-1:0] i_pin_role,
    input wire logic [N_PINS-1:0]   i_pin_hold,
    input wire logic                o_rsp_valid,
    input wire logic [7:0]          o_rsp_data,
    input wire logic                o_notice_valid,
    input wire logic [7:0]          o_notice_data,
    input wire logic [N_PINS-1:0]   o_pin_out,
    input wire logic [N_PINS-1:0]   o_pin_oe,
    input wire logic                o_fabric_en,
    input wire logic                o_nvm_en,
    input wire logic                o_pll_en,
    input wire logic                o_sram_retain,
    input wire logic                o_sram_power,
    input wire logic                o_rtc_wake_sysctl,
    input wire logic                o_rtc_wake_fabric,
    input wire logic                o_rtc_wake_nvic,
    input wire logic                o_freeze_entry_notice,
    input wire logic                o_freeze_exit_done,
    input wire logic                o_frozen
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////////////////
    // pins with no wake part: not single-ended or role off
    logic [N_PINS-1:0] nonwake;
    always_comb begin
        for (int k = 0; k < N_PINS; k++) begin
            nonwake[k] = !i_pin_single_ended[k] || (i_pin_role[2*k+:2] == 2'h0);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_accept;
        o_notice_valid && i_notice_ready;
    endsequence
    sequence s_frozen_ok;
        o_rsp_valid && (o_rsp_data == CMD_OK) && o_frozen;
    endsequence
    AST_NOTICE_DATA: assert property (o_notice_valid |-> o_notice_data == CMD_NOTICE)
        else $error("notice byte wrong");
    AST_NOTICE_HOLD: assert property (o_notice_valid && !i_notice_ready |=>
        o_notice_valid && !o_frozen)
        else $error("freeze went on before notice taken");
    AST_ACCEPT: assert property (s_accept |-> ##2 s_frozen_ok)
        else $error("no ok answer after notice taken");
    AST_ABORT: assert property (i_cmd_valid && (o_frozen || o_notice_valid) |=>
        o_rsp_valid && o_rsp_data == CMD_ABORT && !o_freeze_exit_done)
        else $error("busy request not aborted");
    AST_EN_IDLE: assert property (!o_freeze_entry_notice |->
        o_fabric_en && o_nvm_en && o_pll_en)
        else $error("block disabled outside freeze");
    AST_COPIES: assert property (o_rtc_wake_sysctl == o_rtc_wake_fabric &&
        o_rtc_wake_sysctl == o_rtc_wake_nvic)
        else $error("wake copies differ");
    AST_FORCE: assert property ($rose(i_rtc_wake_force) |-> ##[1:2] o_rtc_wake_sysctl)
        else $error("force gave no wake");
    AST_ENTRY: assert property ($rose(o_freeze_entry_notice) |->
        o_notice_valid && !o_freeze_exit_done)
        else $error("entry without notice");
    AST_TRI: assert property (o_frozen |-> (o_pin_oe & nonwake & ~i_pin_hold) == '0)
        else $error("tristate pin driven in freeze");
    AST_PASS: assert property (!o_freeze_entry_notice |->
        o_pin_out == i_pin_out && o_pin_oe == i_pin_oe)
        else $error("pins not passed through");
    AST_SRAM: assert property (o_frozen |-> o_sram_power == o_sram_retain)
        else $error("sram power wrong in freeze");
endmodule
bind lpfw_ctrl lpfw_ctrl_chk #(.N_PINS(N_PINS)) lpfw_ctrl_chk_i (.*);
`default_nettype wire

// File: lpfw_fifo_model.sv
/* processor-side receive fifo model for the notice byte.
   assumes the bench sets the stall count before each notice. */
`timescale 1ns/10ps
`default_nettype none
module lpfw_fifo_model (
    input  wire logic       i_mclk,
    input  wire logic       i_resetn,
    input  wire logic       i_notice_valid,
    input  wire logic [7:0] i_notice_data,
    input  wire logic [3:0] i_stall,
    output logic            o_ready,
    output logic [7:0]      o_got
);
    logic [3:0] cnt_q, cnt_d;
    logic       rdy_q, rdy_d;
    logic [7:0] got_q, got_d;
    // room appears only after the stall, like a busy fifo
    always_comb begin
        cnt_d = i_notice_valid ? cnt_q + 4'h1 : 4'h0;
        rdy_d = i_notice_valid && (cnt_q >= i_stall);
        got_d = (i_notice_valid && rdy_q) ? i_notice_data : got_q;
    end
    always_ff @(posedge i_mclk) begin
        cnt_q <= i_resetn ? cnt_d : 4'h0;
        rdy_q <= i_resetn ? rdy_d : 1'b0;
        got_q <= i_resetn ? got_d : 8'h00;
    end
    assign o_ready = rdy_q;
    assign o_got   = got_q;
endmodule
`default_nettype wire

// File: tb_lpfw_ctrl.sv
/* self-checking bench for lpfw_ctrl: freeze entry, abort, options,
   pin and forced wake. assumes the fifo model as notice partner. */
`timescale 1ns/10ps
`default_nettype none
module tb_lpfw_ctrl;
    logic i_mclk, i_resetn, i_cmd_valid, i_notice_ready, i_rtc_wake_force;
    logic [7:0] i_cmd_data, o_rsp_data, o_notice_data, got;
    logic [31:0] i_rtc_match;
    logic [7:0] i_pin_in, i_pin_out, i_pin_oe, i_pin_single_ended, i_pin_hold;
    logic [7:0] o_pin_out, o_pin_oe;
    logic [15:0] i_pin_role;
    logic [3:0] stall;
    logic o_cmd_ready, o_rsp_valid, o_notice_valid, o_fabric_en, o_nvm_en;
    logic o_pll_en, o_sram_retain, o_sram_power, o_rtc_wake_sysctl;
    logic o_rtc_wake_fabric, o_rtc_wake_nvic, o_freeze_entry_notice;
    logic o_freeze_exit_done, o_frozen;
    int error_cnt = 0;
    int n_checks = 0;
    lpfw_ctrl #(.N_PINS(8)) lpfw_ctrl_i (.*);
    lpfw_fifo_model lpfw_fifo_model_i (.i_mclk(i_mclk), .i_resetn(i_resetn),
        .i_notice_valid(o_notice_valid), .i_notice_data(o_notice_data),
        .i_stall(stall), .o_ready(i_notice_ready), .o_got(got));
    // fabric side: done is low through freeze, so it is already the low-active reset
    logic pll_async_reset_n, fabric_reset_n;
    assign pll_async_reset_n = o_freeze_exit_done;
    assign fabric_reset_n    = i_resetn && o_freeze_exit_done;
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic send(input logic [7:0] b);
        @(posedge i_mclk);
        i_cmd_valid <= 1'b1;
        i_cmd_data  <= b;
    endtask
    task automatic idle();
        @(posedge i_mclk);
        i_cmd_valid <= 1'b0;
        #1;
    endtask
    // bounded wait for the completion indication
    task automatic wait_done(input int lim);
        int n;
        for (n = 0; n < lim && o_freeze_exit_done !== 1'b1; n++) @(posedge i_mclk) #1;
        check(n < lim, 1);
        check(o_freeze_entry_notice, 0);
        check({pll_async_reset_n, fabric_reset_n}, 2'h3);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // command then option byte, stalled notice, exact latency to frozen
    task automatic freeze(input logic [7:0] opt, input logic [3:0] s);
        int n;
        send(lpfw_pkg::CMD_FREEZE);
        stall <= s;
        send(opt);
        idle();
        check({o_freeze_entry_notice, o_freeze_exit_done, o_notice_valid}, 3'h5);
        for (n = 0; n < 40 && o_frozen !== 1'b1; n++) @(posedge i_mclk) #1;
        check(n, 3 + s);
        check({o_rsp_valid, o_rsp_data}, 9'h100);
        check(got, lpfw_pkg::CMD_NOTICE);
        check({o_fabric_en, o_nvm_en, o_pll_en}, {!opt[0], !opt[1], !opt[2]});
        check({o_sram_retain, o_sram_power}, {opt[3], opt[3]});
        check({pll_async_reset_n, fabric_reset_n}, 2'h0);
    endtask
    task automatic t_reset();
        send(8'h22);
        idle();
        check(o_cmd_ready, 1);
        check({o_rsp_valid, o_freeze_entry_notice, o_freeze_exit_done}, 3'h1);
        check({o_pin_out, o_pin_oe}, {i_pin_out, i_pin_oe});
        $display("test reset done");
    endtask
    // option table, abort while frozen, forced counter wake
    task automatic t_opts();
        logic [7:0] tbl [4] = '{8'h11, 8'h12, 8'h1c, 8'h1f};
        int n;
        for (int i = 0; i < 4; i++) begin
            freeze(tbl[i], 4'(2 * i));
            send(lpfw_pkg::CMD_FREEZE);
            idle();
            check({o_rsp_valid, o_rsp_data, o_frozen}, 10'h3f5);
            @(posedge i_mclk) i_rtc_wake_force <= 1'b1;
            @(posedge i_mclk) i_rtc_wake_force <= 1'b0;
            #1;
            for (n = 0; n < 8 && o_rtc_wake_sysctl !== 1'b1; n++) @(posedge i_mclk) #1;
            check({o_rtc_wake_sysctl, o_rtc_wake_fabric, o_rtc_wake_nvic}, 3'h7);
            wait_done(20);
        end
        $display("test options done");
    endtask
    // signature needs all pins; non-wake pins hold or tristate
    task automatic t_sig();
        freeze(8'h00, 4'h1);
        @(posedge i_mclk);
        i_pin_out <= 8'haa;
        i_pin_in  <= 8'h08;
        repeat (10) @(posedge i_mclk);
        #1;
        check(o_frozen, 1);
        check(o_pin_oe & 8'hc8, 8'h00);
        check({o_pin_out & 8'h30, o_pin_oe & 8'h30}, 16'h1030);
        @(posedge i_mclk) i_pin_in <= 8'h00;
        repeat (10) @(posedge i_mclk);
        #1;
        check(o_frozen, 1);
        @(posedge i_mclk) i_pin_in <= 8'h02;
        wait_done(20);
        @(posedge i_mclk);
        i_pin_in  <= 8'h01;
        i_pin_out <= 8'h55;
        $display("test signature done");
    endtask
    // activity pin wakes on a rise and on a fall
    task automatic t_act();
        for (int k = 0; k < 2; k++) begin
            freeze(8'h00, 4'h0);
            repeat (5) @(posedge i_mclk);
            #1;
            check(o_frozen, 1);
            @(posedge i_mclk) i_pin_in <= i_pin_in ^ 8'h04;
            wait_done(20);
        end
        $display("test activity done");
    endtask
    // counter wake after two ticks of the 1 MHz enable, counted in cycles
    task automatic t_rtc();
        int n;
        @(posedge i_mclk) i_rtc_match <= 32'h0000_0002;
        freeze(8'h10, 4'h0);
        for (n = 0; n < 100 && o_rtc_wake_sysctl !== 1'b1; n++) @(posedge i_mclk) #1;
        check(n, 2 * (lpfw_pkg::CLK_HZ / lpfw_pkg::RTC_HZ));
        wait_done(20);
        $display("test counter done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_resetn = 1'b0;
        i_cmd_valid = 1'b0;
        i_cmd_data = 8'h00;
        i_rtc_match = 32'hffff_ffff;
        i_rtc_wake_force = 1'b0;
        i_pin_in = 8'h01;
        i_pin_out = 8'h55;
        i_pin_oe = 8'hff;
        i_pin_single_ended = 8'hf7;
        i_pin_role = 16'h00f9;
        i_pin_hold = 8'h30;
        stall = 4'h0;
        repeat (16) @(posedge i_mclk);
        i_resetn <= 1'b1;
        t_reset();
        t_opts();
        t_sig();
        t_act();
        t_rtc();
        end_of_test();
    end
    // watchdog well past the expected run length
    initial begin
        #800000;
        error_cnt++;
        end_of_test();
    end
endmodule
`default_nettype wire
